// >>> core/adcseq_top.sv
/*
 Conversion mode sequencer for an 8-channel successive-approximation
 converter: control registers, mode sequencing, start and stop, result
 storage and the end-of-conversion request.
 Assumes an analog front end on the same clock that presents SAR_DATA for
 the channel on CHAN_SEL at the end of each conversion, and a register port
 whose read data is expected one cycle after the read strobe.
*/
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "adcseq_map.svh"
module adcseq_top
   import adcseq_pkg::*;
(
   // Clock and reset
   input  wire logic                    CLK,
   input  wire logic                    RST,
   // Register port
   input  wire logic [`ADCSEQ_AW-1:0]   REG_ADDR,
   input  wire logic [7:0]              REG_WDATA,
   input  wire logic                    REG_WR,
   input  wire logic                    REG_RD,
   output logic      [7:0]              REG_RDATA,
   // Converter front end
   input  wire logic [9:0]              SAR_DATA,
   output logic      [2:0]              CHAN_SEL,
   output logic                         CONV_ACTIVE,
   output logic                         VREF_CONNECT,
   // External start pin
   input  wire logic                    EXT_CONV_TRIGGER,
   // End-of-conversion interrupt request
   output logic                         CONV_DONE_REQ
);

   adcseq_ctrl0_s c0;
   adcseq_ctrl1_s c1;
   adcseq_state_e state;
   logic [5:0]    cnt;
   logic [2:0]    chan;
   logic          cur_emph;
   logic [2:0]    other_ptr;
   logic [1:0]    emph_ptr;
   logic          trig_m;
   logic          trig_s;
   logic          trig_d;

   // Register decode
   wire wr_c0 = REG_WR && REG_ADDR == `ADCSEQ_CTRL0_OFS;
   wire wr_c1 = REG_WR && REG_ADDR == `ADCSEQ_CTRL1_OFS;
   wire rd_res = REG_ADDR >= `ADCSEQ_RES_BASE && REG_ADDR <= `ADCSEQ_RES_LAST;
   wire [7:0] res_rd;

   // Trigger pin, synchronised then edge detected
   wire trig_edge = trig_s && !trig_d;

   // Sweep group decode
   wire [2:0] group_last = {c1.sweep_group_sel_hi, c1.sweep_group_sel_lo, 1'b1};
   wire [2:0] emph_last  = {1'b0, c1.sweep_group_sel_hi, c1.sweep_group_sel_lo};

   // Effective mode
   wire emph_mode  = c1.emph;
   wire m_oneshot  = !emph_mode && c0.mode == MODE_ONESHOT;
   wire m_repeat   = !emph_mode && c0.mode == MODE_REPEAT;
   wire m_sweep    = !emph_mode && c0.mode == MODE_SWEEP;
   wire m_single   = m_oneshot || m_repeat;
   // Trigger starts only the three trigger-capable modes
   wire use_trig   = c0.trig_sel && !emph_mode && c0.mode != MODE_RSWEEP;

   // Conversion timing
   wire       tick;
   wire [5:0] last_cnt = (c1.res10 ? `ADCSEQ_TICKS_10 : `ADCSEQ_TICKS_8) - 6'h01;
   wire       conv_end = state == ST_CONV && tick && cnt == last_cnt;

   // Finishing conversions of the one-time modes
   wire fin_event = conv_end && (m_oneshot || (m_sweep && chan == group_last));

   // First channel of a run
   wire [2:0] first_chan = m_single ? c0.chan : 3'h0;

   // Next channel after a conversion
   wire [2:0] other_nxt = (other_ptr == 3'h7) ? emph_last + 3'h1 : other_ptr + 3'h1;
   wire [1:0] emph_nxt  = (emph_ptr == emph_last[1:0]) ? 2'h0 : emph_ptr + 2'h1;
   wire [2:0] sweep_nxt = (chan == group_last) ? 3'h0 : chan + 3'h1;

   // State decode
   logic          start_run;
   adcseq_state_e next_state;

   assign start_run = (state == ST_IDLE && c0.start && !use_trig)
                   || (state == ST_ARMED && trig_edge);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (c0.start) next_state = use_trig ? ST_ARMED : ST_CONV;
         end
         ST_ARMED: begin
            if (trig_edge) next_state = ST_CONV;
         end
         ST_CONV: begin
            if (fin_event) next_state = use_trig ? ST_ARMED : ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      // Clearing the flag overrides every state
      if (!c0.start) next_state = ST_IDLE;
   end

   // Control registers; a software write wins over the hardware clear
   always_ff @(posedge CLK) begin
      if (RST) begin
         c0 <= adcseq_ctrl0_s'(`ADCSEQ_CTRL0_RST);
      end else if (wr_c0) begin
         c0 <= adcseq_ctrl0_s'(REG_WDATA);
      end else if (fin_event && !use_trig) begin
         c0.start <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) c1 <= adcseq_ctrl1_s'(`ADCSEQ_CTRL1_RST);
      else if (wr_c1) c1 <= adcseq_ctrl1_s'({2'h0, REG_WDATA[`ADCSEQ_CTRL1_MSB:0]});
   end

   // Trigger synchroniser
   always_ff @(posedge CLK) begin
      if (RST) begin
         trig_m <= 1'b0;
         trig_s <= 1'b0;
         trig_d <= 1'b0;
      end else begin
         trig_m <= EXT_CONV_TRIGGER;
         trig_s <= trig_m;
         trig_d <= trig_s;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) state <= ST_IDLE;
      else state <= next_state;
   end

   // Conversion length counter
   always_ff @(posedge CLK) begin
      if (RST || state != ST_CONV || conv_end) cnt <= 6'h00;
      else if (tick) cnt <= cnt + 6'h01;
   end

   // Channel sequencing
   always_ff @(posedge CLK) begin
      if (RST) begin
         chan      <= 3'h0;
         cur_emph  <= 1'b0;
         other_ptr <= 3'h0;
         emph_ptr  <= 2'h0;
      end else if (start_run) begin
         chan      <= first_chan;
         cur_emph  <= emph_mode;
         other_ptr <= emph_last + 3'h1;
         emph_ptr  <= (emph_last == 3'h0) ? 2'h0 : 2'h1;
      end else if (conv_end && emph_mode) begin
         // Emphasised channels sit between each of the others
         if (cur_emph) begin
            chan      <= other_ptr;
            other_ptr <= other_nxt;
         end else begin
            chan     <= {1'b0, emph_ptr};
            emph_ptr <= emph_nxt;
         end
         cur_emph <= !cur_emph;
      end else if (conv_end && !m_single) begin
         chan <= sweep_nxt;
      end
   end

   // Request pulse only at the end of one-shot or a whole sweep
   always_ff @(posedge CLK) begin
      if (RST) CONV_DONE_REQ <= 1'b0;
      else CONV_DONE_REQ <= fin_event;
   end

   // Read data stand for one cycle only
   wire [7:0] rd_mux = (REG_ADDR == `ADCSEQ_CTRL0_OFS) ? c0 :
                       (REG_ADDR == `ADCSEQ_CTRL1_OFS) ? c1 :
                       rd_res ? res_rd : 8'h00;

   always_ff @(posedge CLK) begin
      if (RST) REG_RDATA <= 8'h00;
      else REG_RDATA <= REG_RD ? rd_mux : 8'h00;
   end

   assign CHAN_SEL     = chan;
   assign CONV_ACTIVE  = state == ST_CONV;
   assign VREF_CONNECT = c1.vref;

   adcseq_clkdiv u_div (
      .CLK      (CLK),
      .RST      (RST),
      .div_sel  (c1.conv_clock_div_sel),
      .div_pair (c0.div_pair),
      .tick     (tick)
   );

   // Every completed conversion is kept, also while repeating
   adcseq_results u_res (
      .CLK     (CLK),
      .RST     (RST),
      .wr_en   (conv_end),
      .wr_idx  (chan),
      .wr_data (SAR_DATA),
      .res10   (c1.res10),
      .rd_idx  (REG_ADDR[3:1]),
      .rd_hi   (REG_ADDR[0]),
      .rd_data (res_rd)
   );

   // Checks

   oneshot_req_a: assert property (@(posedge CLK) disable iff (RST)
      conv_end && m_oneshot |=> CONV_DONE_REQ)
      else $error("one-shot end without request");

   repeat_noreq_a: assert property (@(posedge CLK) disable iff (RST)
      (m_repeat || emph_mode || c0.mode == MODE_RSWEEP) |=> !CONV_DONE_REQ)
      else $error("request raised in a repeating mode");

   sweep_end_a: assert property (@(posedge CLK) disable iff (RST)
      CONV_DONE_REQ && $past(m_sweep) |-> $past(chan) == $past(group_last))
      else $error("sweep request before last channel");

   sweep_wrap_a: assert property (@(posedge CLK) disable iff (RST)
      conv_end && c0.mode == MODE_RSWEEP && !emph_mode && chan == group_last
      |=> chan == 3'h0)
      else $error("sweep did not wrap to first channel");

   emph_other_a: assert property (@(posedge CLK) disable iff (RST)
      conv_end && emph_mode && cur_emph |=> !cur_emph && chan > emph_last)
      else $error("emphasis not followed by another channel");

   sw_start_a: assert property (@(posedge CLK) disable iff (RST)
      state == ST_IDLE && c0.start && !use_trig |=> state == ST_CONV)
      else $error("software start ignored");

   trig_start_a: assert property (@(posedge CLK) disable iff (RST)
      state == ST_ARMED && trig_edge && c0.start |=> state == ST_CONV)
      else $error("trigger start ignored");

   flag_clear_a: assert property (@(posedge CLK) disable iff (RST)
      fin_event && !use_trig && !wr_c0 |=> !c0.start ##1 state == ST_IDLE)
      else $error("start flag not cleared at finish");

   trig_keep_a: assert property (@(posedge CLK) disable iff (RST)
      fin_event && use_trig && !wr_c0 |=> c0.start && state == ST_ARMED)
      else $error("trigger run lost its armed state");

   stop_write_a: assert property (@(posedge CLK) disable iff (RST)
      wr_c0 && !REG_WDATA[`ADCSEQ_START_BIT] |=> ##1 state == ST_IDLE && !CONV_ACTIVE)
      else $error("stop write did not stop conversion");

   flag_track_a: assert property (@(posedge CLK) disable iff (RST)
      state == ST_CONV && $past(state) == ST_CONV |-> $past(c0.start))
      else $error("converting with start flag low");

   oneshot_c: cover property (@(posedge CLK) disable iff (RST)
      conv_end && m_oneshot ##1 CONV_DONE_REQ);
   sweep_c: cover property (@(posedge CLK) disable iff (RST)
      fin_event && m_sweep && group_last == 3'h7);
   emph_c: cover property (@(posedge CLK) disable iff (RST)
      conv_end && emph_mode && !cur_emph);
   trig_c: cover property (@(posedge CLK) disable iff (RST)
      state == ST_ARMED && trig_edge);

endmodule // adcseq_top
`default_nettype wire

// >>> core/adcseq_map.svh
/*
 Address map, field positions, reset values and timing counts of the
 converter sequencer. Assumes an 8-bit register port with 10-bit addresses.
*/
//
// Overview of operation
// - Two-bit sweep group picks 2, 4, 6 or 8 channels, or 1-4 emphasised channels.
// - Emphasis bit set selects emphasis repeat-sweep; cleared leaves the configured mode.
// - Resolution bit: 0 gives 8-bit results, 1 gives 10-bit results.
// - Divider bit with its companion bit picks the conversion clock division.
// - Reference bit 1 connects the reference to the ladder, 0 isolates it.
// - One-shot converts the chosen channel once and requests an interrupt at the end.
// - Repeat converts the chosen channel until stopped, with no interrupt.
// - Single sweep converts each group channel once, interrupt after the whole sweep.
// - One-shot, repeat and sweep start on a start-flag write or the selected trigger.
// - One-shot and sweep clear the start flag at the end, unless trigger-started.
// - Writing 0 to the start flag stops conversion in every mode.
// - In repeat modes each result register updates and is readable at any time.
// - Each result lands in the register of the channel converted.
// - 10-bit results: low eight bits at even address, top two at odd.
// - Emphasis mode sweeps all channels, emphasised ones between each, no interrupt.
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH

`define ADCSEQ_AW        10
`define ADCSEQ_CTRL0_OFS 10'h3D6
`define ADCSEQ_CTRL1_OFS 10'h3D7
`define ADCSEQ_RES_BASE  10'h3C0
`define ADCSEQ_RES_LAST  10'h3CF
`define ADCSEQ_CTRL0_RST 8'h00
`define ADCSEQ_CTRL1_RST 8'h00
`define ADCSEQ_START_BIT 6
`define ADCSEQ_CTRL1_MSB 5
`define ADCSEQ_TICKS_8   6'h1C
`define ADCSEQ_TICKS_10  6'h21

`endif

// >>> core/adcseq_pkg.sv
/*
 Types of the converter sequencer: modes, states and register layouts.
 Assumes the map header is compiled alongside.
*/
package adcseq_pkg;

   typedef enum logic [1:0] {
      MODE_ONESHOT,
      MODE_REPEAT,
      MODE_SWEEP,
      MODE_RSWEEP
   } adcseq_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_CONV
   } adcseq_state_e;

   typedef struct packed {
      logic         div_pair;
      logic         start;
      logic         trig_sel;
      adcseq_mode_e mode;
      logic [2:0]   chan;
   } adcseq_ctrl0_s;

   typedef struct packed {
      logic [1:0]   rsvd;
      logic         vref;
      logic         conv_clock_div_sel;
      logic         res10;
      logic         emph;
      logic         sweep_group_sel_hi;
      logic         sweep_group_sel_lo;
   } adcseq_ctrl1_s;

endpackage

// >>> core/adcseq_clkdiv.sv
/*
 Conversion clock enable divider.
 Assumes settings change only while conversion is stopped.
*/
`timescale 1ns/1ns
`default_nettype none
module adcseq_clkdiv
   import adcseq_pkg::*;
(
   // Clock and reset
   input  wire logic CLK,
   input  wire logic RST,
   // Divider settings
   input  wire logic div_sel,
   input  wire logic div_pair,
   // Conversion clock enable
   output logic      tick
);
   logic [1:0] cnt;
   wire  [1:0] tc = div_sel ? (div_pair ? 2'h2 : 2'h0) : (div_pair ? 2'h3 : 2'h1);

   // Greater-or-equal lets a shortened ratio take effect without a long wrap
   assign tick = (cnt >= tc);

   always_ff @(posedge CLK) begin
      if (RST || tick) cnt <= 2'h0;
      else cnt <= cnt + 2'h1;
   end

   div_four_a: assert property (@(posedge CLK) disable iff (RST)
      tick && tc == 2'h3 |=> (tc != 2'h3 || !tick) [*3])
      else $error("divide-by-four spacing broken");

endmodule // adcseq_clkdiv
`default_nettype wire

// >>> core/adcseq_results.sv
/*
 Per-channel result storage, one 10-bit entry per channel.
 Assumes the converter data are valid in the cycle of wr_en.
*/
`timescale 1ns/1ns
`default_nettype none
module adcseq_results
   import adcseq_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RST,
   // Write side
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_idx,
   input  wire logic [9:0] wr_data,
   input  wire logic       res10,
   // Read side
   input  wire logic [2:0] rd_idx,
   input  wire logic       rd_hi,
   output logic      [7:0] rd_data
);
   logic [9:0] mem [8];
   wire  [9:0] val = res10 ? wr_data : {2'h0, wr_data[9:2]};

   genvar k;
   generate
      for (k = 0; k < 8; k++) begin : g_ent
         always_ff @(posedge CLK) begin
            if (RST) mem[k] <= 10'h000;
            else if (wr_en && wr_idx == k) mem[k] <= val;
         end
      end
   endgenerate

   // Odd address holds the top two bits, zero in 8-bit mode
   assign rd_data = rd_hi ? {6'h00, mem[rd_idx][9:8]} : mem[rd_idx][7:0];

   store_val_a: assert property (@(posedge CLK) disable iff (RST)
      wr_en |=> mem[$past(wr_idx)] == $past(val))
      else $error("result not stored in its channel entry");

   res8_hi_a: assert property (@(posedge CLK) disable iff (RST)
      wr_en && !res10 |=> mem[$past(wr_idx)][9:8] == 2'h0)
      else $error("8-bit result has upper bits");

   hold_ent_a: assert property (@(posedge CLK) disable iff (RST)
      !(wr_en && wr_idx == 3'h0) |=> $stable(mem[0]))
      else $error("idle result entry changed");

endmodule // adcseq_results
`default_nettype wire

// >>> bench/adcseq_front_model.sv
/*
 Front-end model of the converter sequencer: presents one result per channel.
 Assumes the sequencer samples SAR data only while its conversion is active.
*/
`timescale 1ns/1ns
`default_nettype none
module adcseq_front_model (
   // Clock
   input  wire logic       CLK,
   // Sequencer side
   input  wire logic [2:0] chan,
   input  wire logic       active,
   input  wire logic [9:0] base,
   output logic      [9:0] data
);
   logic [9:0] junk = 10'h2AA;
   // Outside a conversion the value holds at 10'h2AA, so a late or early sample shows up
   always_ff @(posedge CLK) begin
      junk <= ~junk + 10'h155;
   end
   assign data = active ? (base ^ {chan, 4'h0, chan}) : junk;
endmodule // adcseq_front_model
`default_nettype wire

// >>> bench/testbench.sv
/*
 Self-checking bench of the converter sequencer: registers, all modes,
 trigger start and stop. Assumes the front-end model and the map header.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adcseq_map.svh"
module testbench;
   import adcseq_pkg::*;
   localparam logic [9:0] c0a = `ADCSEQ_CTRL0_OFS;
   localparam logic [9:0] c1a = `ADCSEQ_CTRL1_OFS;
   localparam logic [9:0] rb  = `ADCSEQ_RES_BASE;
   logic                  CLK, RST, REG_WR, REG_RD, CONV_ACTIVE, VREF_CONNECT;
   logic                  CONV_DONE_REQ, EXT_CONV_TRIGGER;
   logic [9:0]            REG_ADDR, SAR_DATA, base;
   logic [7:0]            REG_WDATA, REG_RDATA, lf;
   logic [9:0]            raw [8];
   logic [2:0]            CHAN_SEL, ch;
   logic [2:0]            seq [6];
   logic [1:0]            g;
   int                    n_fail, tests_run, n_done, n_act, dn, i, j, k, n;

   adcseq_top u_dut (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SAR_DATA(SAR_DATA),
      .CHAN_SEL(CHAN_SEL), .CONV_ACTIVE(CONV_ACTIVE), .VREF_CONNECT(VREF_CONNECT),
      .EXT_CONV_TRIGGER(EXT_CONV_TRIGGER), .CONV_DONE_REQ(CONV_DONE_REQ));
   adcseq_front_model u_front (.CLK(CLK), .chan(CHAN_SEL), .active(CONV_ACTIVE),
      .base(base), .data(SAR_DATA));

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      if (CONV_DONE_REQ === 1'b1) n_done <= n_done + 1;
      if (CONV_ACTIVE === 1'b1) n_act <= n_act + 1;
   end

   function automatic logic [7:0] nxt(logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic [7:0] mk0(logic st, logic tg, adcseq_mode_e m, logic [2:0] c);
      return {1'b0, st, tg, m, c};
   endfunction
   // 8-bit results come from the top eight bits; the odd byte then reads 0
   function automatic logic [7:0] expr(logic [9:0] d, logic r10, logic h);
      if (h) return r10 ? {6'h00, d[9:8]} : 8'h00;
      return r10 ? d[7:0] : d[9:2];
   endfunction
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [9:0] a, logic [7:0] d);
      @(posedge CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rdc(logic [9:0] a, logic [7:0] e);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 chk(REG_RDATA, e);
   endtask
   task automatic rdres(logic [2:0] c, logic r10);
      rdc(rb + {6'h00, c, 1'b0}, expr(raw[c], r10, 1'b0));
      rdc(rb + {6'h00, c, 1'b1}, expr(raw[c], r10, 1'b1));
   endtask
   // Bounded wait for the done pulse, or for the sequencer to go idle
   task automatic wait_on(logic done, int lim);
      for (k = 0; k < lim && (done ? CONV_DONE_REQ : ~CONV_ACTIVE) !== 1'b1; k++)
         @(posedge CLK) #1;
      if (k == lim) begin
         n_fail++;
         results();
      end
   endtask
   // Bounded capture of the first six channels of a repeating run, each differing from the one before
   task automatic grab();
      for (n = 0, j = 0; n < 2000 && j < 6; n++) begin
         @(posedge CLK) #1;
         if (CONV_ACTIVE === 1'b1 && (j == 0 || CHAN_SEL !== seq[j - 1])) begin
            seq[j] = CHAN_SEL;
            j++;
         end
      end
      if (j < 6) begin
         n_fail++;
         results();
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = 10'h000;
      REG_WDATA = 8'h00;
      EXT_CONV_TRIGGER = 1'b0;
      base = 10'h000;
      {n_fail, tests_run, n_done, n_act} = '0;
      lf = 8'h5C;
      RST = 1'b1;
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      rdc(c1a, `ADCSEQ_CTRL1_RST);
      rdc(c0a, `ADCSEQ_CTRL0_RST);
      rdc(10'h3D0, 8'h00);
      lf = nxt(lf);
      wr(c1a, lf);
      rdc(c1a, lf & 8'h3F);
      chk({7'h00, VREF_CONNECT}, {7'h00, lf[5]});
      $display("test registers done");
      // One-shot at every divider setting, both resolutions
      for (i = 0; i < 4; i++) begin
         lf = nxt(lf);
         base = {lf, 2'b11};
         ch = lf[2:0];
         n = i[0] ? (i[1] ? 3 : 1) : (i[1] ? 4 : 2);
         wr(c1a, {3'b001, i[0], i[1] ^ i[0], 3'b000});
         wr(c0a, {i[1], 2'b00, MODE_ONESHOT, ch});
         dn = n_done;
         n_act = 0;
         wr(c0a, {i[1], 1'b1, 1'b0, MODE_ONESHOT, ch});
         wait_on(1'b1, 2000);
         j = (i[1] ^ i[0]) ? 33 : 28;
         chk({7'h00, n_act > (j - 1) * n && n_act <= (j + 1) * n}, 8'h01);
         repeat (3) @(posedge CLK);
         chk(8'(n_done - dn), 8'h01);
         rdc(c0a, {i[1], 1'b0, 1'b0, MODE_ONESHOT, ch});
         raw[ch] = base ^ {ch, 4'h0, ch};
         rdres(ch, i[1] ^ i[0]);
      end
      $display("test one-shot done");
      // Sweeps: the first covers all channels, later ones must leave the rest alone
      for (i = 0; i < 4; i++) begin
         g = i[1:0] + 2'b11;
         lf = nxt(lf);
         base = {lf, 2'b01};
         wr(c1a, {6'b001110, g});
         wr(c0a, mk0(1'b0, 1'b0, MODE_SWEEP, 3'h0));
         dn = n_done;
         wr(c0a, mk0(1'b1, 1'b0, MODE_SWEEP, 3'h0));
         wait_on(1'b1, 3000);
         repeat (3) @(posedge CLK);
         chk(8'(n_done - dn), 8'h01);
         rdc(c0a, mk0(1'b0, 1'b0, MODE_SWEEP, 3'h0));
         for (j = 0; j < 8; j++) begin
            if (j < 2 * g + 2) raw[j] = base ^ {j[2:0], 4'h0, j[2:0]};
            rdres(j[2:0], 1'b1);
         end
      end
      $display("test sweep done");
      lf = nxt(lf);
      base = {lf, 2'b10};
      ch = lf[5:3];
      wr(c1a, 8'h38);
      wr(c0a, mk0(1'b0, 1'b0, MODE_REPEAT, ch));
      dn = n_done;
      wr(c0a, mk0(1'b1, 1'b0, MODE_REPEAT, ch));
      repeat (100) @(posedge CLK);
      raw[ch] = base ^ {ch, 4'h0, ch};
      rdres(ch, 1'b1);
      chk({7'h00, CONV_ACTIVE}, 8'h01);
      rdc(c0a, mk0(1'b1, 1'b0, MODE_REPEAT, ch));
      wr(c0a, mk0(1'b0, 1'b0, MODE_REPEAT, ch));
      wait_on(1'b0, 4);
      chk(8'(n_done - dn), 8'h00);
      $display("test repeat done");
      // Emphasis overrides the mode field: one emphasised channel between the others
      wr(c1a, 8'h34);
      wr(c0a, mk0(1'b0, 1'b0, MODE_ONESHOT, 3'h0));
      dn = n_done;
      wr(c0a, mk0(1'b1, 1'b0, MODE_ONESHOT, 3'h0));
      grab();
      for (j = 0; j < 6; j++)
         chk({5'h00, seq[j]}, j[0] ? 8'(j / 2 + 1) : 8'h00);
      wr(c0a, mk0(1'b0, 1'b0, MODE_ONESHOT, 3'h0));
      wait_on(1'b0, 4);
      chk(8'(n_done - dn), 8'h00);
      $display("test emphasis done");
      // Repeat sweep over a four-channel group wraps back to the first channel
      wr(c1a, 8'h31);
      wr(c0a, mk0(1'b0, 1'b0, MODE_RSWEEP, 3'h0));
      wr(c0a, mk0(1'b1, 1'b0, MODE_RSWEEP, 3'h0));
      grab();
      for (j = 0; j < 6; j++)
         chk({5'h00, seq[j]}, 8'(j % 4));
      wr(c0a, mk0(1'b0, 1'b0, MODE_RSWEEP, 3'h0));
      wait_on(1'b0, 4);
      chk(8'(n_done - dn), 8'h00);
      $display("test repeat sweep done");
      lf = nxt(lf);
      base = {lf, 2'b00};
      ch = lf[2:0];
      wr(c1a, 8'h30);
      wr(c0a, mk0(1'b0, 1'b1, MODE_ONESHOT, ch));
      wr(c0a, mk0(1'b1, 1'b1, MODE_ONESHOT, ch));
      repeat (10) @(posedge CLK);
      chk({7'h00, CONV_ACTIVE}, 8'h00);
      EXT_CONV_TRIGGER <= 1'b1;
      repeat (3) @(posedge CLK);
      EXT_CONV_TRIGGER <= 1'b0;
      wait_on(1'b1, 200);
      rdc(c0a, mk0(1'b1, 1'b1, MODE_ONESHOT, ch));
      raw[ch] = base ^ {ch, 4'h0, ch};
      rdres(ch, 1'b0);
      wr(c0a, mk0(1'b0, 1'b1, MODE_ONESHOT, ch));
      rdc(c0a, mk0(1'b0, 1'b1, MODE_ONESHOT, ch));
      $display("test trigger done");
      results();
   end
endmodule // testbench
`default_nettype wire
